// ---- design/spic_top.sv ----
// Behaviour
// RULE1: auto select on gives auto, else manual
// RULE2: three select bits choose the program
// RULE3: home return needs auto and instruction
// RULE4: eight home return methods selectable
// RULE5: trouble output on while no alarm
// RULE6: unmapped stroke-end inputs read as on
// RULE7: travel completion only on code 24
// RULE8: input and output functions are reassignable
// RULE9: forced stop open cuts drive, brakes
// RULE10: forced stop closing leaves stop state
// RULE11: controller holds forced stop closed first
// RULE12: dog detected when off, polarity inverts
// RULE13: both limits on to start, sudden stop
// RULE14: each limit off blocks its direction
`timescale 1ns/1ns
module spic_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [spic_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [spic_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [spic_pkg::DATA_W-1:0] reg_rdata_o,
    // External input and output pins
    input wire logic [spic_pkg::IN_PINS-1:0] in_pins_i,
    output logic [spic_pkg::OUT_PINS-1:0] out_pins_o,
    // Drive side status and requests
    input wire logic alarm_i,
    input wire logic motion_done_i,
    input wire logic start_i,
    input wire logic home_instr_i,
    // Mode and program
    output logic auto_mode_o,
    output logic jog_mode_o,
    output logic pulse_gen_mode_o,
    output logic [2:0] program_no_o,
    output logic home_active_o,
    output logic [2:0] home_method_o,
    // Power stage and motion control
    output logic power_stage_on_o,
    output logic dyn_brake_o,
    output logic servo_lock_o,
    output logic fwd_enable_o,
    output logic rev_enable_o,
    // Status
    output logic trouble_out_o,
    output logic dog_detected_o,
    output logic irq_o
);

    spic_map_if map ();

    logic [spic_pkg::ASSIGN_W-1:0] in_assign;
    logic [spic_pkg::ASSIGN_W-1:0] out_assign;
    logic [spic_pkg::CFG_W-1:0] config_reg;
    logic [spic_pkg::IRQ_W-1:0] irq_status;
    logic [spic_pkg::IRQ_W-1:0] irq_mask;
    logic [spic_pkg::IRQ_W-1:0] next_irq_status;
    logic [spic_pkg::IRQ_W-1:0] next_irq_mask;
    logic [spic_pkg::IRQ_W-1:0] events;
    spic_pkg::spic_state_t state;
    spic_pkg::spic_state_t next_state;
    logic alarm_q;
    logic done_q;
    logic f_auto;
    logic f_fstop;
    logic f_dog;
    logic f_fwd;
    logic f_rev;
    logic [2:0] psel;
    logic dog_pol;
    logic limits_ok;
    logic irq_rd_clr;

    // Pin to function routing lives in the mapper
    assign map.pins = in_pins_i;
    assign map.assign_tbl = in_assign;

    spic_pin_map u_map (
        .map(map)
    );

    // Function levels as seen after routing
    assign f_auto = map.funcs[spic_pkg::FN_AUTO];
    assign f_fstop = map.funcs[spic_pkg::FN_FSTOP];
    assign f_dog = map.funcs[spic_pkg::FN_DOG];
    assign f_fwd = map.funcs[spic_pkg::FN_FWD];
    assign f_rev = map.funcs[spic_pkg::FN_REV];
    assign psel = {map.funcs[spic_pkg::FN_PSEL3], map.funcs[spic_pkg::FN_PSEL2],
                   map.funcs[spic_pkg::FN_PSEL1]};
    assign dog_pol = config_reg[spic_pkg::CFG_DOG_POL];
    assign limits_ok = f_fwd & f_rev;
    assign irq_rd_clr = reg_rd_i && (reg_addr_i == spic_pkg::OFS_IRQ_STATUS);

    // Decode an output pin's function code to its level
    function automatic logic spic_out_level(input logic [7:0] code,
                                            input logic done,
                                            input logic alarm);
        if (code == spic_pkg::CODE_TRAVEL)
        begin
            return done;
        end
        if (code == spic_pkg::CODE_TROUBLE)
        begin
            return ~alarm;
        end
        return 1'b0;
    endfunction : spic_out_level

    // Configuration writes; one-cycle strobes, no wait states
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            in_assign <= spic_pkg::RST_IN_ASSIGN;
            out_assign <= spic_pkg::RST_OUT_ASSIGN;
            config_reg <= spic_pkg::RST_CONFIG;
            irq_mask <= spic_pkg::RST_IRQ_MASK;
        end
        else if (reg_wr_i)
        begin
            // RULE8: assignment tables written
            case (reg_addr_i)
                spic_pkg::OFS_IN_ASSIGN: in_assign <= reg_wdata_i[spic_pkg::ASSIGN_W-1:0];
                spic_pkg::OFS_OUT_ASSIGN: out_assign <= reg_wdata_i[spic_pkg::ASSIGN_W-1:0];
                spic_pkg::OFS_CONFIG: config_reg <= reg_wdata_i[spic_pkg::CFG_W-1:0];
                spic_pkg::OFS_IRQ_MASK: irq_mask <= reg_wdata_i[spic_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= '0;
        end
        else
        begin
            reg_rdata_o <= '0;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    spic_pkg::OFS_IN_ASSIGN: reg_rdata_o <= {8'h00, in_assign};
                    spic_pkg::OFS_OUT_ASSIGN: reg_rdata_o <= {8'h00, out_assign};
                    spic_pkg::OFS_CONFIG: reg_rdata_o <= {27'h0000000, config_reg};
                    spic_pkg::OFS_STATUS: reg_rdata_o <= {19'h00000, alarm_i, f_auto, f_rev,
                                                          f_fwd, dog_detected_o, f_fstop,
                                                          psel, state};
                    spic_pkg::OFS_IRQ_STATUS: reg_rdata_o <= {28'h0000000, irq_status};
                    spic_pkg::OFS_IRQ_MASK: reg_rdata_o <= {28'h0000000, irq_mask};
                    default: reg_rdata_o <= '0;
                endcase
            end
        end
    end

    // Run state; forced stop has priority over everything else
    always_comb
    begin
        next_state = state;
        unique case (state)
            spic_pkg::ST_IDLE:
            begin
                // RULE9: open contact forces stop
                if (!f_fstop)
                    next_state = spic_pkg::ST_FSTOP;
                // RULE13: start needs both limits
                else if (start_i && limits_ok && !alarm_i)
                    next_state = spic_pkg::ST_RUN;
            end
            spic_pkg::ST_RUN:
            begin
                if (!f_fstop)
                    next_state = spic_pkg::ST_FSTOP;
                // RULE13: limit off, sudden stop
                else if (!limits_ok)
                    next_state = spic_pkg::ST_LOCK;
                else if (alarm_i)
                    next_state = spic_pkg::ST_IDLE;
            end
            spic_pkg::ST_LOCK:
            begin
                // Held servo-locked until forced stop, or a fresh start with both limits on and no alarm
                if (!f_fstop)
                    next_state = spic_pkg::ST_FSTOP;
                else if (start_i && limits_ok && !alarm_i)
                    next_state = spic_pkg::ST_RUN;
            end
            spic_pkg::ST_FSTOP:
            begin
                // RULE10: closing contact releases stop
                if (f_fstop)
                    next_state = spic_pkg::ST_IDLE;
            end
            default: next_state = spic_pkg::ST_FSTOP;
        endcase
    end

    // State register; reset lands in the safe stop state until inputs are seen
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            state <= spic_pkg::ST_FSTOP;
        else
            state <= next_state;
    end

    // Power stage outputs follow the next state so they line up with state
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            power_stage_on_o <= 1'b0;
            dyn_brake_o <= 1'b1;
            servo_lock_o <= 1'b0;
            fwd_enable_o <= 1'b0;
            rev_enable_o <= 1'b0;
        end
        else
        begin
            // RULE9: drive off, brake on
            power_stage_on_o <= (next_state != spic_pkg::ST_FSTOP);
            dyn_brake_o <= (next_state == spic_pkg::ST_FSTOP);
            servo_lock_o <= (next_state == spic_pkg::ST_LOCK);
            // RULE14: per-direction motion block
            fwd_enable_o <= (next_state == spic_pkg::ST_RUN) & f_fwd;
            rev_enable_o <= (next_state == spic_pkg::ST_RUN) & f_rev;
        end
    end

    // Mode, program and home return selection
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            auto_mode_o <= 1'b0;
            jog_mode_o <= 1'b0;
            pulse_gen_mode_o <= 1'b0;
            program_no_o <= 3'h0;
            home_active_o <= 1'b0;
            home_method_o <= 3'h0;
        end
        else
        begin
            // RULE1: auto or manual mode
            auto_mode_o <= f_auto;
            jog_mode_o <= !f_auto && (config_reg[spic_pkg::CFG_MANUAL_KIND] ==
                                      spic_pkg::MAN_JOG);
            pulse_gen_mode_o <= !f_auto && (config_reg[spic_pkg::CFG_MANUAL_KIND] ==
                                            spic_pkg::MAN_PULSE_GEN);
            // RULE2: program number select
            program_no_o <= psel;
            // RULE3: home return in auto only
            home_active_o <= f_auto && home_instr_i && (next_state == spic_pkg::ST_RUN);
            // RULE4: method from config
            home_method_o <= config_reg[spic_pkg::CFG_HOME_LSB +: 3];
        end
    end

    // Trouble, dog and mapped output pins
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            trouble_out_o <= 1'b0;
            dog_detected_o <= 1'b0;
            out_pins_o <= '0;
        end
        else
        begin
            // RULE5: on while alarm-free
            trouble_out_o <= ~alarm_i;
            // RULE12: off means detected
            dog_detected_o <= f_dog ~^ dog_pol;
            // RULE7: travel completion by code
            for (int i = 0; i < spic_pkg::OUT_PINS; i++)
                out_pins_o[i] <= spic_out_level(out_assign[8*i +: 8], motion_done_i, alarm_i);
        end
    end

    // Event edges for the interrupt status
    assign events[spic_pkg::IRQ_ALARM] = alarm_i & ~alarm_q;
    assign events[spic_pkg::IRQ_FSTOP] = (next_state == spic_pkg::ST_FSTOP) &&
                                         (state != spic_pkg::ST_FSTOP);
    assign events[spic_pkg::IRQ_LIMIT] = (next_state == spic_pkg::ST_LOCK) &&
                                         (state == spic_pkg::ST_RUN);
    assign events[spic_pkg::IRQ_TRAVEL] = motion_done_i & ~done_q;
    // A new event wins over the read that clears
    assign next_irq_status = (irq_rd_clr ? '0 : irq_status) | events;
    // Mask as it stands after this edge, so a mask write moves irq_o in step
    assign next_irq_mask = (reg_wr_i && (reg_addr_i == spic_pkg::OFS_IRQ_MASK)) ?
                           reg_wdata_i[spic_pkg::IRQ_W-1:0] : irq_mask;

    // Sticky status, read-clear, masked level interrupt
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            alarm_q <= 1'b0;
            done_q <= 1'b0;
            irq_status <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            alarm_q <= alarm_i;
            done_q <= motion_done_i;
            irq_status <= next_irq_status;
            irq_o <= |(next_irq_status & next_irq_mask);
        end
    end

    a_auto_mode_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
        f_auto |=> auto_mode_o && !jog_mode_o && !pulse_gen_mode_o)
        else $error("auto select did not give auto mode");

    a_program_no_follows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE2
        ##1 program_no_o == $past(psel))
        else $error("program number does not follow select bits");

    a_home_method_cfg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4
        ##1 home_method_o == $past(config_reg[spic_pkg::CFG_HOME_LSB +: 3]))
        else $error("home method differs from config");

    a_trouble_on_alarm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE5
        alarm_i |=> !trouble_out_o ##0 (trouble_out_o == !$past(alarm_i)))
        else $error("trouble output wrong for alarm");

    a_unmapped_limit_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE6
        (in_assign[3*spic_pkg::FN_FWD +: 3] == spic_pkg::PIN_NONE) |-> f_fwd)
        else $error("unmapped forward limit not on");

    a_unmapped_rev_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE6
        (in_assign[3*spic_pkg::FN_REV +: 3] == spic_pkg::PIN_NONE) |-> f_rev)
        else $error("unmapped reverse limit not on");

    a_fstop_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE9
        !f_fstop |=> (state == spic_pkg::ST_FSTOP) && dyn_brake_o && !power_stage_on_o)
        else $error("forced stop not entered with brake");

    a_fstop_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE10
        (state == spic_pkg::ST_FSTOP) && f_fstop |=> state == spic_pkg::ST_IDLE)
        else $error("forced stop not left on close");

    a_dog_polarity: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
        !dog_pol && !f_dog |=> dog_detected_o)
        else $error("dog not detected with input off");

    a_limit_sudden_stop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE13
        (state == spic_pkg::ST_RUN) && f_fstop && !limits_ok |=>
        (state == spic_pkg::ST_LOCK) && servo_lock_o && !fwd_enable_o && !rev_enable_o)
        else $error("limit off did not servo-lock");

    a_start_needs_limits: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE13
        $rose(state == spic_pkg::ST_RUN) |-> $past(limits_ok) && $past(start_i))
        else $error("run started without both limits");

    a_fwd_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE14
        !f_fwd |=> !fwd_enable_o)
        else $error("forward motion not blocked");

    a_rev_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE14
        !f_rev |=> !rev_enable_o)
        else $error("reverse motion not blocked");

    a_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        irq_o == |(irq_status & irq_mask))
        else $error("interrupt level disagrees with status");

    // Travel completion appears on a pin only when its code selects it
    genvar gp;
    generate
        for (gp = 0; gp < spic_pkg::OUT_PINS; gp++)
        begin : g_chk
            a_travel_pin_code: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE7
                (out_assign[8*gp +: 8] == spic_pkg::CODE_TRAVEL) |=>
                out_pins_o[gp] == $past(motion_done_i))
                else $error("travel completion pin wrong");
        end
    endgenerate

endmodule : spic_top

// ---- pkg/spic_pkg.sv ----
package spic_pkg;

    // Bus and pin geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int IN_PINS = 7;
    localparam int OUT_PINS = 3;
    localparam int FUNCS = 8;
    localparam int SEL_W = 3;
    localparam int CODE_W = 8;
    localparam int IRQ_W = 4;
    localparam int ASSIGN_W = 24;
    localparam int CFG_W = 5;

    // Register byte addresses
    localparam logic [4:0] OFS_IN_ASSIGN = 5'h00;
    localparam logic [4:0] OFS_OUT_ASSIGN = 5'h04;
    localparam logic [4:0] OFS_CONFIG = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;

    // Input function slots, three select bits each in the input assignment word
    localparam int FN_AUTO = 0;
    localparam int FN_PSEL1 = 1;
    localparam int FN_PSEL2 = 2;
    localparam int FN_PSEL3 = 3;
    localparam int FN_FSTOP = 4;
    localparam int FN_DOG = 5;
    localparam int FN_FWD = 6;
    localparam int FN_REV = 7;
    localparam logic [2:0] PIN_NONE = 3'h7;
    // Level seen by a function with no pin: limits and forced stop read on
    localparam logic [7:0] UNASSIGNED_LEVEL = 8'hD0;

    // Output function codes
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_TROUBLE = 8'h03;
    localparam logic [7:0] CODE_TRAVEL = 8'h18;

    // Config field positions
    localparam int CFG_DOG_POL = 0;
    localparam int CFG_HOME_LSB = 1;
    localparam int CFG_MANUAL_KIND = 4;

    // Interrupt bit positions
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_FSTOP = 1;
    localparam int IRQ_LIMIT = 2;
    localparam int IRQ_TRAVEL = 3;

    // Reset values
    localparam logic [23:0] RST_IN_ASSIGN = 24'hFAC688;
    localparam logic [23:0] RST_OUT_ASSIGN = 24'h001803;
    localparam logic [4:0] RST_CONFIG = 5'h00;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_LOCK = 4'h4,
        ST_FSTOP = 4'h8
    } spic_state_t;

    typedef enum logic [2:0] {
        HOME_DOG = 3'h0,
        HOME_COUNT = 3'h1,
        HOME_DATA_SET = 3'h2,
        HOME_STOPPER = 3'h3,
        HOME_SERVO_ON_POS = 3'h4,
        HOME_DOG_REAR = 3'h5,
        HOME_COUNT_FRONT = 3'h6,
        HOME_DOG_CRADLE = 3'h7
    } spic_home_t;

    typedef enum logic {
        MAN_JOG = 1'b0,
        MAN_PULSE_GEN = 1'b1
    } spic_manual_t;

endpackage : spic_pkg

// ---- pkg/spic_map_if.sv ----
`timescale 1ns/1ns
interface spic_map_if;
    logic [spic_pkg::IN_PINS-1:0] pins;
    logic [spic_pkg::ASSIGN_W-1:0] assign_tbl;
    logic [spic_pkg::FUNCS-1:0] funcs;

    modport mapper (input pins, input assign_tbl, output funcs);
    modport core (output pins, output assign_tbl, input funcs);
endinterface : spic_map_if

// ---- design/spic_pin_map.sv ----
`timescale 1ns/1ns
module spic_pin_map (
    // Pin levels and assignment table in, function levels out
    spic_map_if.mapper map
);

    // Route one pin to a function, or a fixed level when the slot has no pin
    function automatic logic spic_pick(input logic [spic_pkg::IN_PINS-1:0] pins,
                                       input logic [2:0] sel,
                                       input logic dflt);
        if (sel == spic_pkg::PIN_NONE)
        begin
            return dflt;
        end
        return pins[sel];
    endfunction : spic_pick

    // One selector per input function
    // RULE6: unmapped slot fixed level
    genvar g;
    generate
        for (g = 0; g < spic_pkg::FUNCS; g++)
        begin : g_fn
            assign map.funcs[g] = spic_pick(map.pins, map.assign_tbl[3*g +: 3],
                                            spic_pkg::UNASSIGNED_LEVEL[g]);
        end
    endgenerate

endmodule : spic_pin_map

// ---- test/spic_partner.sv ----
`timescale 1ns/1ns
// Controller, limit switches and dog sensor seen at the input pins
module spic_partner (
    // Clock
    input wire logic core_clk_i,
    // Pin side
    output logic [6:0] pins_o,
    output logic start_o,
    output logic home_instr_o
);
    // Idle: auto on, forced stop closed, dog on, forward limit on
    initial
    begin
        pins_o = 7'h71;
        start_o = 1'b0;
        home_instr_o = 1'b0;
    end
    // Switch one pin just after an edge
    task set_pin(input int idx, input logic lvl);
        @(posedge core_clk_i);
        pins_o[idx] <= lvl;
    endtask : set_pin
    // One-cycle start pulse; any forces it past the safety gate
    task start(input logic home, input logic any);
        @(posedge core_clk_i);
        home_instr_o <= home & pins_o[0];
        if (any || (pins_o[4] && pins_o[6]))
            start_o <= 1'b1;
        @(posedge core_clk_i);
        start_o <= 1'b0;
    endtask : start
endmodule : spic_partner

// ---- test/servo_positioning_input_control_test.sv ----
`timescale 1ns/1ns
module servo_positioning_input_control_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic alarm = 1'b0;
    logic done = 1'b0;
    logic [31:0] rdata;
    logic [6:0] pins;
    logic start;
    logic home;
    logic [2:0] out_pins;
    logic auto_m, jog_m, pg_m, home_act, pwr, brake, lock, fwd_en, rev_en;
    logic trouble, dog, irq;
    logic [2:0] prog_no;
    logic [2:0] home_m;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] d;

    // 20 MHz clock
    always #25 clk = ~clk;

    spic_top i_spic_top (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .in_pins_i(pins), .out_pins_o(out_pins), .alarm_i(alarm), .motion_done_i(done),
        .start_i(start), .home_instr_i(home), .auto_mode_o(auto_m), .jog_mode_o(jog_m),
        .pulse_gen_mode_o(pg_m), .program_no_o(prog_no), .home_active_o(home_act),
        .home_method_o(home_m), .power_stage_on_o(pwr), .dyn_brake_o(brake),
        .servo_lock_o(lock), .fwd_enable_o(fwd_en), .rev_enable_o(rev_en),
        .trouble_out_o(trouble), .dog_detected_o(dog), .irq_o(irq));

    spic_partner i_spic_partner (.core_clk_i(clk), .pins_o(pins), .start_o(start),
        .home_instr_o(home));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Pin path plus state register; a margin over the one-cycle latency
    task settle();
        repeat (3) @(posedge clk);
    endtask : settle

    task reg_wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // Data stand only in the cycle after the strobe
    task reg_rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd

    task t_reset();
        reg_rd(spic_pkg::OFS_IN_ASSIGN, d);
        check(d, {8'h00, spic_pkg::RST_IN_ASSIGN});
        reg_rd(spic_pkg::OFS_OUT_ASSIGN, d);
        check(d, {8'h00, spic_pkg::RST_OUT_ASSIGN});
        reg_rd(spic_pkg::OFS_CONFIG, d);
        check(d, 32'h0);
        reg_rd(spic_pkg::OFS_IRQ_MASK, d);
        check(d, 32'h0);
        reg_rd(5'h18, d);
        check(d, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task t_mode();
        settle();
        check(auto_m, 1'b1);
        i_spic_partner.set_pin(0, 1'b0);
        settle();
        check({auto_m, jog_m, pg_m}, 3'h2);
        reg_wr(spic_pkg::OFS_CONFIG, 32'h10);
        settle();
        check({auto_m, jog_m, pg_m}, 3'h1);
        reg_wr(spic_pkg::OFS_CONFIG, 32'h0);
        i_spic_partner.set_pin(0, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            for (int b = 0; b < 3; b++)
                i_spic_partner.set_pin(b + 1, i[b]);
            settle();
            check(prog_no, i[2:0]);
        end
        $display("test mode done");
    endtask : t_mode

    task t_fstop();
        reg_rd(spic_pkg::OFS_IRQ_STATUS, d);
        reg_wr(spic_pkg::OFS_IRQ_MASK, 32'hF);
        i_spic_partner.start(1'b0, 1'b0);
        settle();
        check({pwr, brake}, 2'h2);
        i_spic_partner.set_pin(4, 1'b0);
        settle();
        check({pwr, brake, irq}, 3'h3);
        reg_rd(spic_pkg::OFS_IRQ_STATUS, d);
        check(d[1], 1'b1);
        i_spic_partner.set_pin(4, 1'b1);
        settle();
        check(irq, 1'b0);
        reg_rd(spic_pkg::OFS_STATUS, d);
        check(d[3:0], 4'h1);
        $display("test forced stop done");
    endtask : t_fstop

    task t_limit();
        i_spic_partner.start(1'b0, 1'b0);
        settle();
        check({fwd_en, rev_en, lock}, 3'h6);
        i_spic_partner.set_pin(6, 1'b0);
        settle();
        check({fwd_en, lock}, 2'h1);
        reg_rd(spic_pkg::OFS_IRQ_STATUS, d);
        check(d[2], 1'b1);
        i_spic_partner.start(1'b0, 1'b1);
        settle();
        check(lock, 1'b1);
        i_spic_partner.set_pin(6, 1'b1);
        reg_wr(spic_pkg::OFS_IN_ASSIGN, 32'h7AC688);
        i_spic_partner.set_pin(3, 1'b0);
        i_spic_partner.start(1'b0, 1'b0);
        settle();
        reg_rd(spic_pkg::OFS_STATUS, d);
        check(d[3:0], 4'h4);
        i_spic_partner.set_pin(3, 1'b1);
        i_spic_partner.start(1'b0, 1'b0);
        settle();
        reg_rd(spic_pkg::OFS_STATUS, d);
        check(d[3:0], 4'h2);
        reg_wr(spic_pkg::OFS_IN_ASSIGN, {8'h00, spic_pkg::RST_IN_ASSIGN});
        $display("test limits done");
    endtask : t_limit

    task t_outputs();
        check({trouble, out_pins[0]}, 2'h3);
        alarm <= 1'b1;
        settle();
        check({trouble, out_pins[0]}, 2'h0);
        check(out_pins[2], 1'b0);
        alarm <= 1'b0;
        done <= 1'b1;
        settle();
        check(out_pins[1], 1'b1);
        reg_wr(spic_pkg::OFS_OUT_ASSIGN, 32'h001703);
        settle();
        check(out_pins[1], 1'b0);
        reg_wr(spic_pkg::OFS_OUT_ASSIGN, 32'h000303);
        settle();
        check(out_pins[1], 1'b1);
        reg_wr(spic_pkg::OFS_OUT_ASSIGN, {8'h00, spic_pkg::RST_OUT_ASSIGN});
        done <= 1'b0;
        $display("test outputs done");
    endtask : t_outputs

    task t_dog_home();
        settle();
        check(dog, 1'b0);
        i_spic_partner.set_pin(5, 1'b0);
        settle();
        check(dog, 1'b1);
        reg_wr(spic_pkg::OFS_CONFIG, 32'h1);
        settle();
        check(dog, 1'b0);
        for (int m = 0; m < 8; m++)
        begin
            reg_wr(spic_pkg::OFS_CONFIG, m << 1);
            settle();
            check(home_m, m[2:0]);
        end
        i_spic_partner.start(1'b1, 1'b0);
        settle();
        check(home_act, 1'b1);
        i_spic_partner.set_pin(0, 1'b0);
        settle();
        check(home_act, 1'b0);
        $display("test dog and home done");
    endtask : t_dog_home

    task end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // Tests take well under a thousand cycles
    initial
    begin
        #1000000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        repeat (7) @(posedge clk);
        #1 check({pwr, brake}, 2'h1);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_mode();
        t_fstop();
        t_limit();
        t_outputs();
        t_dog_home();
        end_of_test();
    end
endmodule : servo_positioning_input_control_test
